// >>> mcalu_pkg.sv
package mcalu_pkg;
	// Register file indices (operand codes)
	localparam logic [2:0] REG_MASK_IDX = 3'h5;
	localparam logic [2:0] REG_PHI_IDX = 3'h6;
	localparam logic [2:0] REG_PLO_IDX = 3'h7;
	localparam int NUM_REGS = 8;
	// Condition word field positions
	localparam int CW_SHIFT_OUT = 15;
	localparam int CW_CONV_SIGN = 14;
	localparam int CW_CARRY = 13;
	localparam int CW_SAT_HI = 12;
	localparam int CW_SAT_LO = 11;
	localparam int CW_MASK_ZERO = 10;
	localparam int CW_MASK_ONES = 9;
	localparam int CW_UPPER_NZ = 8;
	localparam int CW_LOWER_NZ = 7;
	localparam int CW_SUM_ZERO = 6;
	localparam int CW_SUM_NEG = 5;
	localparam int CW_UNS_UNDER = 4;
	localparam int CW_UNS_OVER = 3;
	localparam int CW_SGN_UNDER = 2;
	localparam int CW_SGN_OVER = 1;
	localparam int CW_IDLE = 0;
	// Reset values
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] COND_RESET = 16'h0001;
	localparam logic [5:0] INDEX_RESET = 6'h00;
	localparam logic [9:0] JUMP_RESET = 10'h000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Saturation limits
	localparam logic [15:0] SAT_SGN_MAX = 16'h7FFF;
	localparam logic [15:0] SAT_SGN_MIN = 16'h8000;
	localparam logic [15:0] SAT_UNS_MAX = 16'hFFFF;
	localparam logic [15:0] SAT_UNS_MIN = 16'h0000;
	// Multiply latency in cycles
	localparam logic [3:0] MUL_CYCLES = 4'h4;
	// Operation codes
	typedef enum logic [3:0] {
		MCALU_NOP = 4'h0,
		MCALU_ADD = 4'h1,
		MCALU_SUB = 4'h2,
		MCALU_AND = 4'h3,
		MCALU_OR = 4'h4,
		MCALU_XOR = 4'h5,
		MCALU_NOT = 4'h6,
		MCALU_SHL = 4'h7,
		MCALU_SHR = 4'h8,
		MCALU_SH32L = 4'h9,
		MCALU_SH32R = 4'hA,
		MCALU_MUL = 4'hB,
		MCALU_COPY = 4'hC,
		MCALU_TOINT = 4'hD,
		MCALU_SETSAT = 4'hE
	} mcalu_op_t;
	// Multiply sequencer states
	typedef enum logic [1:0] {
		MCALU_IDLE = 2'b00,
		MCALU_BUSY = 2'b01,
		MCALU_DONE = 2'b11
	} mcalu_state_t;
	// Program counter sources
	typedef enum logic [1:0] {
		MCALU_PC_INC = 2'h0,
		MCALU_PC_REL = 2'h1,
		MCALU_PC_FAR1 = 2'h2,
		MCALU_PC_FAR2 = 2'h3
	} mcalu_pc_t;
endpackage : mcalu_pkg

// >>> mcalu_addr.sv
`timescale 1ns/10ps
module mcalu_addr
(
	input wire logic [9:0] instr_addr_i,
	input wire logic index_en_i,
	input wire logic [5:0] index_offset_i,
	input wire logic [15:0] pc_i,
	input wire logic [4:0] rel_disp_i,
	output logic [9:0] dram_addr_o,
	output logic [15:0] rel_target_o
);
	// Data RAM address: operand itself, or operand plus index offset
	assign dram_addr_o = index_en_i ? instr_addr_i + {4'h0, index_offset_i} : instr_addr_i;
	// Relative target: sign-extended five-bit displacement
	assign rel_target_o = pc_i + {{11{rel_disp_i[4]}}, rel_disp_i};
endmodule : mcalu_addr

// >>> mcalu_core.sv
`timescale 1ns/10ps
// Overview of operation
// - Five 16-bit general registers serve as sources and destinations.
// - Mask operand register feeds mask operations and works as general register.
// - Multiply and 32-bit shifts write product pair, high and low halves.
// - Product halves are usable individually as general registers.
// - Condition word holds the listed flags from bit 15 to 0.
// - Shifts set shift-out flag to the last bit shifted out.
// - Conversion sign toggles on each removed sign; cleared by reset operand.
// - Carry captures the carry of the latest add or subtract.
// - Saturation select 00 or 10 wraps add and subtract results.
// - Saturation select 01 clamps signed results to 0x8000..0x7FFF.
// - Saturation select 11 clamps unsigned results to 0x0000..0xFFFF.
// - Mask operations set zero and all-ones flags from the result.
// - Multiply or 32-bit shift sets half-nonzero flags from result halves.
// - Add or subtract sets zero and negative flags from the result.
// - Add or subtract sets unsigned and signed under/overflow flags.
// - Idle flag low during multi-cycle operation; decoder only reads it.
// - Requests arriving while busy are ignored; running operation continues.
// - Immediate addressing takes the data RAM address from the operand.
// - Direct addressing selects a register by operand code.
// - Far jump loads program counter from a preloaded jump register.
// - Indexed access adds the index offset when index enable is set.
// - Relative displacement is five-bit two's complement, -16 to +15.
// - Index offset is held in a 6-bit register.
module mcalu_core
	import mcalu_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic RESET_N_I,
	input wire logic OP_VALID_I,
	input wire mcalu_pkg::mcalu_op_t OP_CODE_I,
	input wire logic [2:0] SRC_SEL_I,
	input wire logic [2:0] DST_SEL_I,
	input wire logic USE_IMM_I,
	input wire logic [15:0] IMM_I,
	input wire logic [3:0] SHIFT_AMT_I,
	input wire logic TOINT_RST_I,
	input wire logic WR_EN_I,
	input wire logic [2:0] WR_SEL_I,
	input wire logic [15:0] WR_DATA_I,
	input wire logic [1:0] SAT_I,
	input wire logic IDX_WR_I,
	input wire logic [5:0] IDX_DATA_I,
	input wire logic JR1_WR_I,
	input wire logic JR2_WR_I,
	input wire logic [9:0] JR_DATA_I,
	input wire logic PC_STEP_I,
	input wire mcalu_pkg::mcalu_pc_t PC_SRC_I,
	input wire logic [4:0] REL_DISP_I,
	input wire logic [9:0] INSTR_ADDR_I,
	input wire logic INDEX_EN_I,
	input wire logic [2:0] RD_SEL_I,
	output logic [15:0] RD_DATA_O,
	output logic [15:0] COND_O,
	output logic [9:0] DRAM_ADDR_O,
	output logic [15:0] PC_O
);
	import mcalu_pkg::*;

	logic [15:0] regs_reg [NUM_REGS];
	logic [15:0] cond_reg;
	logic [15:0] cond_next;
	logic [5:0] index_reg;
	logic [9:0] jr1_reg;
	logic [9:0] jr2_reg;
	logic [15:0] pc_reg;
	logic [15:0] pc_next;
	logic [15:0] rd_data_reg;
	logic [9:0] dram_addr_reg;
	mcalu_state_t state_reg;
	mcalu_state_t state_next;
	logic [3:0] mul_cnt_reg;
	logic [31:0] mul_res_reg;

	// Saturating add or subtract with flags
	function automatic logic [20:0] sat_addsub(input logic [15:0] a, input logic [15:0] b,
		input logic sub, input logic [1:0] sat);
		logic [16:0] raw;
		logic s_ovf;
		logic s_unf;
		logic u_ovf;
		logic u_unf;
		logic [15:0] res;
		raw = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		u_ovf = !sub && raw[16];
		u_unf = sub && raw[16];
		s_ovf = (a[15] == (b[15] ^ sub)) && !a[15] && raw[15];
		s_unf = (a[15] == (b[15] ^ sub)) && a[15] && !raw[15];
		res = raw[15:0];
		if (sat == 2'b01)
		begin
			if (s_ovf)
				res = SAT_SGN_MAX;
			else if (s_unf)
				res = SAT_SGN_MIN;
		end
		else if (sat == 2'b11)
		begin
			if (u_ovf)
				res = SAT_UNS_MAX;
			else if (u_unf)
				res = SAT_UNS_MIN;
		end
		return {raw[16], u_unf, u_ovf, s_unf, s_ovf, res};
	endfunction : sat_addsub

	// Decoded operand fetch
	wire idle = (state_reg == MCALU_IDLE);
	wire take_op = OP_VALID_I && idle;
	wire [15:0] src_a = regs_reg[DST_SEL_I];
	wire [15:0] src_b = USE_IMM_I ? IMM_I : regs_reg[SRC_SEL_I];
	wire [15:0] mask_b = regs_reg[REG_MASK_IDX];
	wire [31:0] pair = {regs_reg[REG_PHI_IDX], regs_reg[REG_PLO_IDX]};
	wire [20:0] as_res = sat_addsub(src_a, src_b, OP_CODE_I == MCALU_SUB, cond_reg[CW_SAT_HI:CW_SAT_LO]);
	wire [15:0] and_res = src_a & mask_b;
	wire [15:0] or_res = src_a | mask_b;
	wire [15:0] xor_res = src_a ^ mask_b;
	wire [15:0] not_res = ~mask_b;
	wire [31:0] shl_wide = {16'h0000, src_a} << SHIFT_AMT_I;
	wire [31:0] shr_wide = {src_a, 16'h0000} >> SHIFT_AMT_I;
	wire [63:0] sh32l_wide = {32'h0, pair} << SHIFT_AMT_I;
	wire [63:0] sh32r_wide = {pair, 32'h0} >> SHIFT_AMT_I;
	wire [31:0] mul_prod = {16'h0000, src_a} * {16'h0000, src_b};
	wire [15:0] abs_val = src_a[15] ? 16'h0000 - src_a : src_a;
	wire [9:0] dram_addr_w;
	wire [15:0] rel_target;

	// Last bit shifted out for each shift kind
	wire shl_out = (SHIFT_AMT_I == 4'h0) ? cond_reg[CW_SHIFT_OUT] : shl_wide[16];
	wire shr_out = (SHIFT_AMT_I == 4'h0) ? cond_reg[CW_SHIFT_OUT] : shr_wide[15];
	wire sh32l_out = (SHIFT_AMT_I == 4'h0) ? cond_reg[CW_SHIFT_OUT] : sh32l_wide[32];
	wire sh32r_out = (SHIFT_AMT_I == 4'h0) ? cond_reg[CW_SHIFT_OUT] : sh32r_wide[31];

	// Address generation for data RAM and relative jumps
	mcalu_addr mcalu_addr_inst
	(
		.instr_addr_i(INSTR_ADDR_I),
		.index_en_i(INDEX_EN_I),
		.index_offset_i(index_reg),
		.pc_i(pc_reg),
		.rel_disp_i(REL_DISP_I),
		.dram_addr_o(dram_addr_w),
		.rel_target_o(rel_target)
	);

	// Condition word next value
	always_comb
	begin
		cond_next = cond_reg;
		cond_next[CW_SAT_HI:CW_SAT_LO] = (take_op && OP_CODE_I == MCALU_SETSAT) ?
			SAT_I : cond_reg[CW_SAT_HI:CW_SAT_LO];
		if (take_op)
		begin
			case (OP_CODE_I)
				MCALU_ADD, MCALU_SUB:
				begin
					cond_next[CW_CARRY] = as_res[20];
					cond_next[CW_UNS_UNDER] = as_res[19];
					cond_next[CW_UNS_OVER] = as_res[18];
					cond_next[CW_SGN_UNDER] = as_res[17];
					cond_next[CW_SGN_OVER] = as_res[16];
					cond_next[CW_SUM_ZERO] = (as_res[15:0] == 16'h0000);
					cond_next[CW_SUM_NEG] = as_res[15];
				end
				MCALU_AND, MCALU_OR, MCALU_XOR, MCALU_NOT:
				begin
					cond_next[CW_MASK_ZERO] = (regs_next_mask() == 16'h0000);
					cond_next[CW_MASK_ONES] = (regs_next_mask() == 16'hFFFF);
				end
				MCALU_SHL: cond_next[CW_SHIFT_OUT] = shl_out;
				MCALU_SHR: cond_next[CW_SHIFT_OUT] = shr_out;
				MCALU_SH32L:
				begin
					cond_next[CW_SHIFT_OUT] = sh32l_out;
					cond_next[CW_UPPER_NZ] = |sh32l_wide[31:16];
					cond_next[CW_LOWER_NZ] = |sh32l_wide[15:0];
				end
				MCALU_SH32R:
				begin
					cond_next[CW_SHIFT_OUT] = sh32r_out;
					cond_next[CW_UPPER_NZ] = |sh32r_wide[63:48];
					cond_next[CW_LOWER_NZ] = |sh32r_wide[47:32];
				end
				MCALU_TOINT:
					cond_next[CW_CONV_SIGN] = TOINT_RST_I ? 1'b0 : cond_reg[CW_CONV_SIGN] ^ src_a[15];
				default: cond_next = cond_next;
			endcase
		end
		if (state_reg == MCALU_DONE)
		begin
			cond_next[CW_UPPER_NZ] = |mul_res_reg[31:16];
			cond_next[CW_LOWER_NZ] = |mul_res_reg[15:0];
		end
		cond_next[CW_IDLE] = (state_next == MCALU_IDLE);
	end

	// Mask result selection
	function automatic logic [15:0] regs_next_mask();
		case (OP_CODE_I)
			MCALU_AND: return and_res;
			MCALU_OR: return or_res;
			MCALU_XOR: return xor_res;
			default: return not_res;
		endcase
	endfunction : regs_next_mask

	// Multiply sequencer
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			MCALU_IDLE: if (take_op && OP_CODE_I == MCALU_MUL) state_next = MCALU_BUSY;
			MCALU_BUSY: if (mul_cnt_reg == 4'h1) state_next = MCALU_DONE;
			MCALU_DONE: state_next = MCALU_IDLE;
			default: state_next = MCALU_IDLE;
		endcase
	end

	// Program counter next value
	always_comb
	begin
		pc_next = pc_reg;
		if (PC_STEP_I)
		begin
			case (PC_SRC_I)
				MCALU_PC_INC: pc_next = pc_reg + 16'h0001;
				MCALU_PC_REL: pc_next = rel_target;
				MCALU_PC_FAR1: pc_next = {6'h00, jr1_reg};
				default: pc_next = {6'h00, jr2_reg};
			endcase
		end
	end

	// Sequencer, counter and multiply result
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			state_reg <= MCALU_IDLE;
			mul_cnt_reg <= 4'h0;
			mul_res_reg <= 32'h0;
		end
		else
		begin
			state_reg <= state_next;
			if (take_op && OP_CODE_I == MCALU_MUL)
			begin
				mul_cnt_reg <= MUL_CYCLES;
				mul_res_reg <= mul_prod;
			end
			else if (mul_cnt_reg != 4'h0)
				mul_cnt_reg <= mul_cnt_reg - 4'h1;
		end
	end

	// Register file writes
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_reg[i] <= REG_RESET;
		end
		else if (state_reg == MCALU_DONE)
		begin
			regs_reg[REG_PHI_IDX] <= mul_res_reg[31:16];
			regs_reg[REG_PLO_IDX] <= mul_res_reg[15:0];
		end
		else if (take_op)
		begin
			case (OP_CODE_I)
				MCALU_ADD, MCALU_SUB: regs_reg[DST_SEL_I] <= as_res[15:0];
				MCALU_AND, MCALU_OR, MCALU_XOR, MCALU_NOT: regs_reg[DST_SEL_I] <= regs_next_mask();
				MCALU_SHL: regs_reg[DST_SEL_I] <= shl_wide[15:0];
				MCALU_SHR: regs_reg[DST_SEL_I] <= shr_wide[31:16];
				MCALU_SH32L:
				begin
					regs_reg[REG_PHI_IDX] <= sh32l_wide[31:16];
					regs_reg[REG_PLO_IDX] <= sh32l_wide[15:0];
				end
				MCALU_SH32R:
				begin
					regs_reg[REG_PHI_IDX] <= sh32r_wide[63:48];
					regs_reg[REG_PLO_IDX] <= sh32r_wide[47:32];
				end
				MCALU_COPY: regs_reg[DST_SEL_I] <= regs_reg[SRC_SEL_I];
				MCALU_TOINT: regs_reg[DST_SEL_I] <= abs_val;
				default: regs_reg[DST_SEL_I] <= regs_reg[DST_SEL_I];
			endcase
		end
		else if (WR_EN_I)
			regs_reg[WR_SEL_I] <= WR_DATA_I;
	end

	// Condition word, addressing registers and outputs
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			cond_reg <= COND_RESET;
			index_reg <= INDEX_RESET;
			jr1_reg <= JUMP_RESET;
			jr2_reg <= JUMP_RESET;
			pc_reg <= PC_RESET;
			rd_data_reg <= REG_RESET;
			dram_addr_reg <= JUMP_RESET;
		end
		else
		begin
			cond_reg <= cond_next;
			if (IDX_WR_I)
				index_reg <= IDX_DATA_I;
			if (JR1_WR_I)
				jr1_reg <= JR_DATA_I;
			if (JR2_WR_I)
				jr2_reg <= JR_DATA_I;
			pc_reg <= pc_next;
			rd_data_reg <= regs_reg[RD_SEL_I];
			dram_addr_reg <= dram_addr_w;
		end
	end

	assign RD_DATA_O = rd_data_reg;
	assign COND_O = cond_reg;
	assign DRAM_ADDR_O = dram_addr_reg;
	assign PC_O = pc_reg;

	// Idle flag is low exactly while the multiplier is running
	a_idle_tracks_busy: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_MUL) |=> !COND_O[CW_IDLE] [*5] ##1 COND_O[CW_IDLE])
		else $error("idle flag timing wrong");

	// Busy requests leave flags and destination untouched
	a_busy_ignored: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(state_reg == MCALU_BUSY && OP_VALID_I && !WR_EN_I) |=>
		$stable(cond_reg[CW_SHIFT_OUT:CW_SGN_OVER]) &&
		regs_reg[$past(DST_SEL_I)] == $past(regs_reg[DST_SEL_I]))
		else $error("request accepted while busy");

	// Wrap mode keeps low sixteen bits
	a_wrap_add: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_ADD && cond_reg[CW_SAT_LO] == 1'b0) |=>
		regs_reg[$past(DST_SEL_I)] == 16'($past(src_a) + $past(src_b)))
		else $error("wrap add wrong");

	// Signed saturation on overflow
	a_sat_signed: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_ADD && cond_reg[CW_SAT_HI:CW_SAT_LO] == 2'b01 && as_res[16])
		|=> regs_reg[$past(DST_SEL_I)] == SAT_SGN_MAX)
		else $error("signed clamp wrong");

	// Unsigned saturation on overflow
	a_sat_unsigned: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_ADD && cond_reg[CW_SAT_HI:CW_SAT_LO] == 2'b11 && as_res[18])
		|=> regs_reg[$past(DST_SEL_I)] == SAT_UNS_MAX)
		else $error("unsigned clamp wrong");

	// Mask zero flag follows the AND result
	a_mask_flags: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_AND) |=>
		COND_O[CW_MASK_ZERO] == (regs_reg[$past(DST_SEL_I)] == 16'h0000))
		else $error("mask zero flag wrong");

	// Sum zero flag follows the result
	a_sum_zero: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_SUB) |=>
		COND_O[CW_SUM_ZERO] == (regs_reg[$past(DST_SEL_I)] == 16'h0000))
		else $error("sum zero flag wrong");

	// OR mask operation leaves carry alone
	a_carry_kept: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(take_op && OP_CODE_I == MCALU_OR) |=> $stable(COND_O[CW_CARRY]))
		else $error("carry disturbed");

	// Far jump lands on jump register
	a_far_jump: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(PC_STEP_I && PC_SRC_I == MCALU_PC_FAR1) |=> PC_O == {6'h00, $past(jr1_reg)})
		else $error("far jump target wrong");

	// Relative jump of minus sixteen
	a_rel_jump: assert property (@(posedge REF_CLK_I) disable iff (!RESET_N_I)
		(PC_STEP_I && PC_SRC_I == MCALU_PC_REL && REL_DISP_I == 5'h10) |=>
		PC_O == $past(pc_reg) - 16'h0010)
		else $error("relative jump wrong");
endmodule : mcalu_core

// >>> mcalu_dec_model.sv
`timescale 1ns/10ps
module mcalu_dec_model
	import mcalu_pkg::*;
(
	input wire logic clk_i,
	input wire logic idle_i,
	output logic op_valid_o,
	output mcalu_pkg::mcalu_op_t op_code_o,
	output logic [2:0] src_o,
	output logic [2:0] dst_o,
	output logic use_imm_o,
	output logic [15:0] imm_o,
	output logic [3:0] amt_o,
	output logic toint_rst_o
);
	// Quiet operation fields from time zero
	initial
	begin
		op_valid_o = 1'b0;
		op_code_o = MCALU_NOP;
		src_o = 3'h0;
		dst_o = 3'h0;
		use_imm_o = 1'b0;
		imm_o = 16'h0000;
		amt_o = 4'h0;
		toint_rst_o = 1'b0;
	end

	// Idle flag is only sampled here, never driven
	task automatic wait_idle;
		int k;
		k = 0;
		@(negedge clk_i);
		while (idle_i !== 1'b1 && k < 40)
		begin
			k++;
			@(negedge clk_i);
		end
	endtask : wait_idle

	// One request pulse; pushy skips the idle wait
	task automatic issue(mcalu_op_t o, logic [2:0] d, s, logic ui, logic [15:0] iv,
		logic [3:0] n, logic r, logic pushy);
		if (pushy)
			@(negedge clk_i);
		else
			wait_idle();
		op_valid_o = 1'b1;
		op_code_o = o;
		dst_o = d;
		src_o = s;
		use_imm_o = ui;
		imm_o = iv;
		amt_o = n;
		toint_rst_o = r;
		@(negedge clk_i);
		op_valid_o = 1'b0;
	endtask : issue
endmodule : mcalu_dec_model

// >>> microcore_alu_condition_addressing_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_fail++; $display("[ERR] %s exp=%h got=%h", nm, ex, got); end end
module microcore_alu_condition_addressing_tb_top;
	import mcalu_pkg::*;
	typedef struct {logic [1:0] k; logic [15:0] m; logic [15:0] v; int due;} mcalu_exp_t;
	logic clk, rst_n, op_valid, use_imm, toint_rst, wr_en, idx_wr, jr1_wr, jr2_wr, pc_step, index_en;
	mcalu_op_t op_code;
	mcalu_pc_t pc_src;
	logic [2:0] src_sel, dst_sel, wr_sel, rd_sel;
	logic [15:0] imm, wr_data, rd_data, cond, pc, cm, obs;
	logic [3:0] amt;
	logic [1:0] sat;
	logic [5:0] idx_data;
	logic [9:0] jr_data, instr_addr, dram_addr;
	logic [4:0] rel_disp;
	logic [31:0] p32, x;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	mcalu_exp_t q[$];
	mcalu_exp_t e;
	string nm[4] = '{"rd_data", "cond", "pc", "dram_addr"};
	mcalu_op_t mops[4] = '{MCALU_AND, MCALU_OR, MCALU_XOR, MCALU_NOT};
	logic [15:0] mres[4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0F0F};
	logic [15:0] sa[4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};

	mcalu_core mcalu_core_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n), .OP_VALID_I(op_valid),
		.OP_CODE_I(op_code), .SRC_SEL_I(src_sel), .DST_SEL_I(dst_sel), .USE_IMM_I(use_imm),
		.IMM_I(imm), .SHIFT_AMT_I(amt), .TOINT_RST_I(toint_rst), .WR_EN_I(wr_en),
		.WR_SEL_I(wr_sel), .WR_DATA_I(wr_data), .SAT_I(sat), .IDX_WR_I(idx_wr),
		.IDX_DATA_I(idx_data), .JR1_WR_I(jr1_wr), .JR2_WR_I(jr2_wr), .JR_DATA_I(jr_data),
		.PC_STEP_I(pc_step), .PC_SRC_I(pc_src), .REL_DISP_I(rel_disp),
		.INSTR_ADDR_I(instr_addr), .INDEX_EN_I(index_en), .RD_SEL_I(rd_sel),
		.RD_DATA_O(rd_data), .COND_O(cond), .DRAM_ADDR_O(dram_addr), .PC_O(pc));
	mcalu_dec_model mcalu_dec_model_inst (.clk_i(clk), .idle_i(cond[0]), .op_valid_o(op_valid),
		.op_code_o(op_code), .src_o(src_sel), .dst_o(dst_sel), .use_imm_o(use_imm),
		.imm_o(imm), .amt_o(amt), .toint_rst_o(toint_rst));

	// Clock and cycle count
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	// Oldest expectation is compared once its cycle has come
	always @(negedge clk)
	begin
		while (q.size() > 0 && q[0].due <= cyc)
		begin
			e = q.pop_front();
			obs = e.k == 0 ? rd_data : e.k == 1 ? cond : e.k == 2 ? pc : {6'h00, dram_addr};
			`CHK(nm[e.k], e.v, obs & e.m)
		end
	end

	// Hang guard
	initial
	begin
		#1200000;
		n_fail++;
		final_report();
	end

	task automatic final_report;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Limits by mode: 01 signed, 11 unsigned, else wrap
	function automatic logic [15:0] sat_ref(logic [15:0] a, b, logic sb, logic [1:0] m);
		int s, u;
		s = sb ? $signed(a) - $signed(b) : $signed(a) + $signed(b);
		u = sb ? int'(a) - int'(b) : int'(a) + int'(b);
		if (m == 2'b01 && s > 32767)
			return 16'h7FFF;
		if (m == 2'b01 && s < -32768)
			return 16'h8000;
		if (m == 2'b11 && u > 65535)
			return 16'hFFFF;
		if (m == 2'b11 && u < 0)
			return 16'h0000;
		return u[15:0];
	endfunction : sat_ref

	task automatic expect_q(logic [1:0] k, logic [15:0] m, logic [15:0] v);
		q.push_back('{k, m, v, cyc + 1});
	endtask : expect_q

	task automatic rd(logic [2:0] s, logic [15:0] v);
		@(negedge clk);
		rd_sel = s;
		expect_q(2'd0, 16'hFFFF, v);
	endtask : rd

	task automatic cnd(logic [15:0] m, logic [15:0] v);
		expect_q(2'd1, m, v & m);
	endtask : cnd

	task automatic wr(logic [2:0] s, logic [15:0] v);
		@(negedge clk);
		wr_en = 1'b1;
		wr_sel = s;
		wr_data = v;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr

	task automatic op(mcalu_op_t o, logic [2:0] d, s, logic ui = 1'b0,
		logic [15:0] iv = 16'h0000, logic [3:0] n = 4'h0, logic r = 1'b0);
		mcalu_dec_model_inst.issue(o, d, s, ui, iv, n, r, 1'b0);
	endtask : op

	task automatic pcs(mcalu_pc_t src, logic [4:0] dsp, logic [15:0] v);
		@(negedge clk);
		pc_step = 1'b1;
		pc_src = src;
		rel_disp = dsp;
		expect_q(2'd2, 16'hFFFF, v);
		@(negedge clk);
		pc_step = 1'b0;
	endtask : pcs

	task automatic do_as(logic [2:0] d, s, logic [15:0] a, b, logic sb);
		logic [16:0] t;
		logic [15:0] r;
		wr(d, a);
		wr(s, b);
		op(sb ? MCALU_SUB : MCALU_ADD, d, s);
		t = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
		r = t[15:0];
		cm[13] = t[16];
		cm[6] = r == 16'h0000;
		cm[5] = r[15];
		cm[4] = sb & t[16];
		cm[3] = ~sb & t[16];
		cm[2] = a[15] & (sb ? ~b[15] : b[15]) & ~r[15];
		cm[1] = ~a[15] & (sb ? b[15] : ~b[15]) & r[15];
		rd(d, r);
		cnd(16'hFFFF, cm);
	endtask : do_as

	// Shift on r4 or on the product pair, result and flags
	task automatic sh(mcalu_op_t o, logic [3:0] n);
		op(o, 3'h4, 3'h4, 1'b0, 16'h0000, n);
		if (o == MCALU_SH32L || o == MCALU_SH32R)
		begin
			cm[15] = o == MCALU_SH32L ? p32[32 - n] : p32[n - 1];
			p32 = o == MCALU_SH32L ? p32 << n : p32 >> n;
			cm[8] = |p32[31:16];
			cm[7] = |p32[15:0];
			rd(3'h6, p32[31:16]);
			rd(3'h7, p32[15:0]);
		end
		else
		begin
			cm[15] = o == MCALU_SHL ? x[16 - n] : x[n - 1];
			x = o == MCALU_SHL ? {16'h0000, x[15:0] << n} : x >> n;
			rd(3'h4, x[15:0]);
		end
		cnd(16'hFFFF, cm);
	endtask : sh

	// Main sequence
	initial
	begin
		{rst_n, wr_en, idx_wr, jr1_wr, jr2_wr, pc_step, index_en} = '0;
		{wr_sel, rd_sel, wr_data, sat, idx_data, jr_data, instr_addr, rel_disp} = '0;
		pc_src = MCALU_PC_INC;
		cm = COND_RESET;
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++)
			rd(i[2:0], 16'h0000);
		cnd(16'hFFFF, 16'h0001);
		expect_q(2'd2, 16'hFFFF, 16'h0000);
		// Data RAM addressing
		instr_addr = 10'h3F5;
		expect_q(2'd3, 16'h03FF, 16'h03F5);
		idx_wr = 1'b1;
		idx_data = 6'h3F;
		@(negedge clk);
		idx_wr = 1'b0;
		index_en = 1'b1;
		expect_q(2'd3, 16'h03FF, 16'h0034);
		// Program counter sources
		pcs(MCALU_PC_INC, 5'h00, 16'h0001);
		pcs(MCALU_PC_REL, 5'h0F, 16'h0010);
		pcs(MCALU_PC_REL, 5'h10, 16'h0000);
		jr1_wr = 1'b1;
		jr_data = 10'h014;
		@(negedge clk);
		jr1_wr = 1'b0;
		pcs(MCALU_PC_FAR1, 5'h00, 16'h0014);
		jr2_wr = 1'b1;
		jr_data = 10'h3FF;
		@(negedge clk);
		jr2_wr = 1'b0;
		pcs(MCALU_PC_FAR2, 5'h00, 16'h03FF);
		pcs(MCALU_PC_REL, 5'h1F, 16'h03FE);
		// Register copy leaves flags alone
		wr(3'h0, 16'hA5C3);
		op(MCALU_COPY, 3'h4, 3'h0);
		rd(3'h4, 16'hA5C3);
		cnd(16'hFFFF, cm);
		// Add and subtract corners, then random operands
		do_as(3'h0, 3'h1, 16'h7FFF, 16'h0001, 1'b0);
		do_as(3'h2, 3'h3, 16'hFFFF, 16'h0001, 1'b0);
		do_as(3'h4, 3'h5, 16'h0000, 16'h0001, 1'b1);
		do_as(3'h6, 3'h7, 16'h8000, 16'h0001, 1'b1);
		do_as(3'h5, 3'h0, 16'h1234, 16'h1234, 1'b1);
		x = 32'h1376;
		for (int i = 0; i < 8; i++)
		begin
			x = lfsr(x);
			do_as(3'(x[2:0] % 5), 3'((x[2:0] % 5 + 1) % 5), x[15:0], x[31:16], x[7]);
		end
		// Mask operations against the mask register
		wr(3'h5, 16'hF0F0);
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h0, 16'h0F0F);
			op(mops[i], 3'h0, 3'h5);
			cm[10] = mres[i] == 16'h0000;
			cm[9] = mres[i] == 16'hFFFF;
			rd(3'h0, mres[i]);
			cnd(16'hFFFF, cm);
		end
		// Sign removal and its clear
		wr(3'h0, 16'hFFFB);
		op(MCALU_TOINT, 3'h0, 3'h0);
		cm[14] = 1'b1;
		rd(3'h0, 16'h0005);
		cnd(16'hFFFF, cm);
		wr(3'h1, 16'h0003);
		op(MCALU_TOINT, 3'h1, 3'h1, 1'b0, 16'h0000, 4'h0, 1'b1);
		cm[14] = 1'b0;
		cnd(16'hFFFF, cm);
		// Multiply with a request pushed in while busy
		wr(3'h3, 16'h1234);
		op(MCALU_MUL, 3'h3, 3'h0, 1'b1, 16'h0100);
		mcalu_dec_model_inst.issue(MCALU_ADD, 3'h3, 3'h0, 1'b1, 16'h0001, 4'h0, 1'b0, 1'b1);
		cnd(16'h0001, 16'h0000);
		repeat (2) @(negedge clk);
		mcalu_dec_model_inst.wait_idle();
		cm[8] = 1'b1;
		cm[7] = 1'b1;
		rd(3'h3, 16'h1234);
		rd(3'h6, 16'h0012);
		rd(3'h7, 16'h3400);
		cnd(16'hFFFF, cm);
		wr(3'h3, 16'h0002);
		op(MCALU_MUL, 3'h3, 3'h0, 1'b1, 16'h0003);
		repeat (2) @(negedge clk);
		mcalu_dec_model_inst.wait_idle();
		p32 = 32'h0000_0006;
		cm[8] = 1'b0;
		rd(3'h7, 16'h0006);
		cnd(16'hFFFF, cm);
		// Shifts of both widths
		sh(MCALU_SH32R, 4'h2);
		sh(MCALU_SH32L, 4'hF);
		sh(MCALU_SH32L, 4'hF);
		wr(3'h4, 16'h8001);
		x = 32'h0000_8001;
		sh(MCALU_SHL, 4'h1);
		sh(MCALU_SHR, 4'h1);
		sh(MCALU_SHR, 4'h1);
		// Every saturation mode against four corners
		for (int s = 0; s < 4; s++)
		begin
			sat = s[1:0];
			op(MCALU_SETSAT, 3'h0, 3'h0);
			cnd(16'h1800, 16'(s << 11));
			for (int c = 0; c < 4; c++)
			begin
				wr(3'h0, sa[c]);
				wr(3'h1, 16'h0001);
				op(c[0] ? MCALU_SUB : MCALU_ADD, 3'h0, 3'h1);
				rd(3'h0, sat_ref(sa[c], 16'h0001, c[0], s[1:0]));
			end
		end
		repeat (3) @(negedge clk);
		final_report();
	end
endmodule : microcore_alu_condition_addressing_tb_top
